/* verilog/fsabl_pkg.sv */
// Constants, types and state codes shared by the fieldbus slave state and abort logic
// Notes on behaviour
// - Communication state machine has exactly four states: init, preop, safeop, op.
// - Init: master configures slave registers; no service or process data.
// - Preop: service-data requests are accepted and answered; process data inactive.
// - Safeop: input process data sent; received output data ignored, no motion.
// - Op: service data and both process-data directions active, outputs applied.
// - Master requests state changes; failed transition sets the error flag.
// - Init to preop starts service data; preop to init stops it.
// - Op to preop stops input and output updates, service data kept.
// - Safeop to init stops input updates and mailbox traffic.
// - Op to init stops inputs, outputs and service data together.
// - Only distributed-clock synchronised operation; master must provide it.
// - SYNC1 drives nothing; only SYNC0 paces cyclic work.
// - SYNC0 period must be 125 us, 250 us, 500 us, 1 ms or 2 ms.
// - Failed service-data read or write answers with a 32-bit abort code.
// - Codes for toggle unchanged, protocol timeout, bad command specifier.
// - Codes for unsupported access, read of write-only, write of read-only.
// - Code when subindex 00 must first be zero and is not.
// - Codes for absent object and absent subindex.
// - Codes for unmappable object and mapping exceeding process-data size.
// - Codes for length mismatch, length too long, length too short.
// - Codes for value out of range, too large, too small.
// - Codes for state forbids storing, and general error.
// - State reported one-hot: 1 init, 2 preop, 4 safeop, 8 op.
package fsabl_pkg;

  typedef enum {ST_INIT, ST_PREOP, ST_SAFEOP, ST_OP} fsabl_state_type;

  localparam logic [3:0] CODE_INIT = 4'h1;
  localparam logic [3:0] CODE_PREOP = 4'h2;
  localparam logic [3:0] CODE_SAFEOP = 4'h4;
  localparam logic [3:0] CODE_OP = 4'h8;

  typedef enum logic [4:0] {
    CAUSE_NONE, CAUSE_TOGGLE, CAUSE_TIMEOUT, CAUSE_BAD_CMD, CAUSE_NO_ACCESS,
    CAUSE_READ_WO, CAUSE_WRITE_RO, CAUSE_SUB0_NONZERO, CAUSE_NO_OBJECT,
    CAUSE_NO_SUBINDEX, CAUSE_NOT_MAPPABLE, CAUSE_MAP_TOO_LONG, CAUSE_LEN_MISMATCH,
    CAUSE_LEN_HIGH, CAUSE_LEN_LOW, CAUSE_VALUE_RANGE, CAUSE_VALUE_HIGH,
    CAUSE_VALUE_LOW, CAUSE_STATE_BLOCKS, CAUSE_GENERAL
  } fsabl_cause_type;

  localparam logic [31:0] ABORT_TOGGLE = 32'h05030000;
  localparam logic [31:0] ABORT_TIMEOUT = 32'h05040000;
  localparam logic [31:0] ABORT_BAD_CMD = 32'h05040001;
  localparam logic [31:0] ABORT_NO_ACCESS = 32'h06010000;
  localparam logic [31:0] ABORT_READ_WO = 32'h06010001;
  localparam logic [31:0] ABORT_WRITE_RO = 32'h06010002;
  localparam logic [31:0] ABORT_SUB0_NONZERO = 32'h06010003;
  localparam logic [31:0] ABORT_NO_OBJECT = 32'h06020000;
  localparam logic [31:0] ABORT_NOT_MAPPABLE = 32'h06040041;
  localparam logic [31:0] ABORT_MAP_TOO_LONG = 32'h06040042;
  localparam logic [31:0] ABORT_LEN_MISMATCH = 32'h06070010;
  localparam logic [31:0] ABORT_LEN_HIGH = 32'h06070012;
  localparam logic [31:0] ABORT_LEN_LOW = 32'h06070013;
  localparam logic [31:0] ABORT_NO_SUBINDEX = 32'h06090011;
  localparam logic [31:0] ABORT_VALUE_RANGE = 32'h06090030;
  localparam logic [31:0] ABORT_VALUE_HIGH = 32'h06090031;
  localparam logic [31:0] ABORT_VALUE_LOW = 32'h06090032;
  localparam logic [31:0] ABORT_GENERAL = 32'h08000000;
  localparam logic [31:0] ABORT_STATE_BLOCKS = 32'h08000022;

  localparam logic [2:0] CMD_DN_SEG = 3'h0;
  localparam logic [2:0] CMD_DN_INIT = 3'h1;
  localparam logic [2:0] CMD_UP_INIT = 3'h2;
  localparam logic [2:0] CMD_UP_SEG = 3'h3;
  localparam logic [2:0] CMD_ABORT = 3'h4;

  localparam int CLK_MHZ = 250;
  localparam int SYNC_BASE_US = 125;
  localparam int SYNC_OPTIONS = 5;
  localparam int SYNC_JITTER_NS = 1000;
  localparam int SDO_TIMEOUT_MS = 100;
  localparam logic [19:0] SYNC_BASE_CYC = 20'(SYNC_BASE_US * CLK_MHZ);
  localparam logic [19:0] SYNC_TOL_CYC = 20'((SYNC_JITTER_NS * CLK_MHZ) / 1000);
  localparam logic [31:0] SDO_TIMEOUT_CYC = 32'(SDO_TIMEOUT_MS * CLK_MHZ * 1000);

endpackage : fsabl_pkg

/* verilog/fsabl_abort_enc.sv */
// Abort cause to 32-bit abort code translation
`timescale 1ns/10ps
`default_nettype none
module fsabl_abort_enc (
  input wire fsabl_pkg::fsabl_cause_type cause,
  output logic [31:0] code
);
  import fsabl_pkg::*;

  always_comb begin
    case (cause)
      CAUSE_TOGGLE: code = ABORT_TOGGLE;
      CAUSE_TIMEOUT: code = ABORT_TIMEOUT;
      CAUSE_BAD_CMD: code = ABORT_BAD_CMD;
      CAUSE_NO_ACCESS: code = ABORT_NO_ACCESS;
      CAUSE_READ_WO: code = ABORT_READ_WO;
      CAUSE_WRITE_RO: code = ABORT_WRITE_RO;
      CAUSE_SUB0_NONZERO: code = ABORT_SUB0_NONZERO;
      CAUSE_NO_OBJECT: code = ABORT_NO_OBJECT;
      CAUSE_NO_SUBINDEX: code = ABORT_NO_SUBINDEX;
      CAUSE_NOT_MAPPABLE: code = ABORT_NOT_MAPPABLE;
      CAUSE_MAP_TOO_LONG: code = ABORT_MAP_TOO_LONG;
      CAUSE_LEN_MISMATCH: code = ABORT_LEN_MISMATCH;
      CAUSE_LEN_HIGH: code = ABORT_LEN_HIGH;
      CAUSE_LEN_LOW: code = ABORT_LEN_LOW;
      CAUSE_VALUE_RANGE: code = ABORT_VALUE_RANGE;
      CAUSE_VALUE_HIGH: code = ABORT_VALUE_HIGH;
      CAUSE_VALUE_LOW: code = ABORT_VALUE_LOW;
      CAUSE_STATE_BLOCKS: code = ABORT_STATE_BLOCKS;
      CAUSE_GENERAL: code = ABORT_GENERAL;
      CAUSE_NONE: code = 32'h00000000;
      default: code = ABORT_GENERAL;
    endcase
  end

endmodule : fsabl_abort_enc
`default_nettype wire

/* verilog/fsabl_sync_check.sv */
// SYNC0 period measurement against the permitted cycle options
`timescale 1ns/10ps
`default_nettype none
module fsabl_sync_check #(
  parameter logic [19:0] BASE_CYC = fsabl_pkg::SYNC_BASE_CYC,
  parameter logic [19:0] TOL_CYC = fsabl_pkg::SYNC_TOL_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic syncEdge,
  output logic periodOk,
  output logic periodErr
);
  import fsabl_pkg::*;

  logic [19:0] gapCount;
  logic seenEdge;
  logic [19:0] gapLimit;

  function automatic logic periodMatch(input logic [19:0] n);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < SYNC_OPTIONS; k++) begin
      if ((n + TOL_CYC >= (BASE_CYC << k)) && (n <= (BASE_CYC << k) + TOL_CYC)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : periodMatch

  // Longest legal gap; beyond it the pulse train counts as lost
  assign gapLimit = (BASE_CYC << (SYNC_OPTIONS - 1)) + TOL_CYC;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      gapCount <= 20'h00000;
      seenEdge <= 1'b0;
      periodOk <= 1'b0;
      periodErr <= 1'b0;
    end else begin
      periodErr <= 1'b0;
      if (syncEdge) begin
        gapCount <= 20'h00001;
        seenEdge <= 1'b1;
        if (seenEdge) begin
          periodOk <= periodMatch(gapCount);
          periodErr <= ~periodMatch(gapCount);
        end
      end else if (gapCount <= gapLimit) begin
        gapCount <= gapCount + 20'h00001;
      end else if (periodOk) begin
        periodOk <= 1'b0;
        periodErr <= 1'b1;
      end
    end
  end

endmodule : fsabl_sync_check
`default_nettype wire

/* verilog/fsabl_top.sv */
// Slave communication state machine, SYNC0 pacing and service-data abort answers
`timescale 1ns/10ps
`default_nettype none
module fsabl_top #(
  parameter logic [19:0] SYNC_BASE = fsabl_pkg::SYNC_BASE_CYC,
  parameter logic [19:0] SYNC_TOL = fsabl_pkg::SYNC_TOL_CYC,
  parameter logic [31:0] SDO_TIMEOUT = fsabl_pkg::SDO_TIMEOUT_CYC
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Master state requests
  input wire logic stateReqValid,
  input wire logic [3:0] stateReq,
  input wire logic errAck,
  // Distributed-clock event pin
  input wire logic sync0Pin,
  // Process data from the link controller
  input wire logic rxPdoValid,
  // Service-data requests
  input wire logic sdoReqValid,
  input wire logic [2:0] sdoCmd,
  input wire logic sdoToggle,
  input wire logic sdoSegmented,
  input wire logic sdoLastSeg,
  input wire logic sdoNeedsPreop,
  input wire fsabl_pkg::fsabl_cause_type sdoCause,
  // State report
  output logic [3:0] commState,
  output logic errorFlag,
  output logic stateAck,
  output logic stateNak,
  // Exchange enables
  output logic sdoEnable,
  output logic mailboxEnable,
  output logic txPdoEnable,
  output logic rxPdoEnable,
  // Cyclic work
  output logic syncOk,
  output logic txPdoUpdate,
  output logic rxPdoApply,
  output logic rxPdoDropped,
  // Service-data answer
  output logic sdoRespValid,
  output logic sdoRespAbort,
  output logic [31:0] sdoAbortCode
);
  import fsabl_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  fsabl_state_type state;
  fsabl_state_type next_state;
  fsabl_state_type reqTarget;
  logic reqOk;
  logic syncFault;
  logic sync0Meta;
  logic sync0Sync;
  logic sync0Last;
  logic sync0Edge;
  logic periodOk;
  logic periodErr;
  logic segActive;
  logic expToggle;
  logic [31:0] idleCount;
  logic timeoutHit;
  logic sdoTake;
  logic isSeg;
  logic isInit;
  fsabl_cause_type reqCause;
  fsabl_cause_type respCause;
  logic [31:0] respCode;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic codeValid(input logic [3:0] code);
    return (code == CODE_INIT) || (code == CODE_PREOP) ||
           (code == CODE_SAFEOP) || (code == CODE_OP);
  endfunction : codeValid

  function automatic fsabl_state_type codeToState(input logic [3:0] code);
    case (code)
      CODE_PREOP: return ST_PREOP;
      CODE_SAFEOP: return ST_SAFEOP;
      CODE_OP: return ST_OP;
      default: return ST_INIT;
    endcase
  endfunction : codeToState

  function automatic logic [3:0] stateToCode(input fsabl_state_type s);
    case (s)
      ST_PREOP: return CODE_PREOP;
      ST_SAFEOP: return CODE_SAFEOP;
      ST_OP: return CODE_OP;
      default: return CODE_INIT;
    endcase
  endfunction : stateToCode

  // Supported transitions; a request for the present state is accepted as no change
  function automatic logic transitionOk(input fsabl_state_type cur, input fsabl_state_type tgt);
    logic ok;
    ok = 1'b0;
    if (cur == tgt) begin
      ok = 1'b1;
    end else begin
      case (cur)
        ST_INIT: ok = (tgt == ST_PREOP);
        ST_PREOP: ok = (tgt == ST_INIT) || (tgt == ST_SAFEOP);
        ST_SAFEOP: ok = (tgt == ST_PREOP) || (tgt == ST_OP) || (tgt == ST_INIT);
        ST_OP: ok = (tgt == ST_SAFEOP) || (tgt == ST_PREOP) || (tgt == ST_INIT);
        default: ok = 1'b0;
      endcase
    end
    return ok;
  endfunction : transitionOk

  // ----------------------------------------------------------------
  // SYNC0 input; SYNC1 has no pin since nothing may run from it
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync0Meta <= 1'b0;
      sync0Sync <= 1'b0;
      sync0Last <= 1'b0;
    end else begin
      sync0Meta <= sync0Pin;
      sync0Sync <= sync0Meta;
      sync0Last <= sync0Sync;
    end
  end

  assign sync0Edge = sync0Sync & ~sync0Last;

  fsabl_sync_check #(
    .BASE_CYC(SYNC_BASE),
    .TOL_CYC(SYNC_TOL)
  ) u_sync_check (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .syncEdge(sync0Edge),
    .periodOk(periodOk),
    .periodErr(periodErr)
  );

  // Losing a valid SYNC0 train while exchanging process data is a fault
  assign syncFault = periodErr & ((state == ST_SAFEOP) || (state == ST_OP));

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      syncOk <= 1'b0;
    end else begin
      syncOk <= periodOk;
    end
  end

  // ----------------------------------------------------------------
  // Communication state machine
  // ----------------------------------------------------------------
  assign reqTarget = codeToState(stateReq);

  // Free-run or event-driven operation is not offered: process-data states need SYNC0
  assign reqOk = codeValid(stateReq) && transitionOk(state, reqTarget) &&
                 (periodOk || (reqTarget == ST_INIT) || (reqTarget == ST_PREOP));

  always_comb begin
    next_state = state;
    if (syncFault && (state == ST_OP)) begin
      next_state = ST_SAFEOP;
    end else if (stateReqValid && reqOk) begin
      next_state = reqTarget;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= ST_INIT;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      commState <= CODE_INIT;
    end else begin
      commState <= stateToCode(next_state);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stateAck <= 1'b0;
      stateNak <= 1'b0;
    end else begin
      stateAck <= stateReqValid & reqOk & ~(syncFault & (state == ST_OP));
      stateNak <= stateReqValid & (~reqOk | (syncFault & (state == ST_OP)));
    end
  end

  // Set wins over the acknowledge so a fresh failure is never lost
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      errorFlag <= 1'b0;
    end else if ((stateReqValid && !reqOk) || syncFault) begin
      errorFlag <= 1'b1;
    end else if (errAck) begin
      errorFlag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Exchange enables follow the state being entered
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sdoEnable <= 1'b0;
      mailboxEnable <= 1'b0;
    end else begin
      // Started on init to preop, stopped on any entry into init
      sdoEnable <= (next_state != ST_INIT);
      mailboxEnable <= (next_state != ST_INIT);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      txPdoEnable <= 1'b0;
      rxPdoEnable <= 1'b0;
    end else begin
      // Preop and init hold both directions off
      txPdoEnable <= (next_state == ST_SAFEOP) || (next_state == ST_OP);
      rxPdoEnable <= (next_state == ST_OP);
    end
  end

  // ----------------------------------------------------------------
  // Cyclic process data: inputs paced by SYNC0 only, outputs taken on rxPdoValid
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      txPdoUpdate <= 1'b0;
    end else begin
      txPdoUpdate <= sync0Edge & txPdoEnable & periodOk;
    end
  end

  // Output data outside op is swallowed so no motion comes from it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rxPdoApply <= 1'b0;
      rxPdoDropped <= 1'b0;
    end else begin
      rxPdoApply <= rxPdoValid & rxPdoEnable;
      rxPdoDropped <= rxPdoValid & ~rxPdoEnable;
    end
  end

  // ----------------------------------------------------------------
  // Service-data checking
  // ----------------------------------------------------------------
  // Requests in init are not seen at all: no answer is produced
  assign sdoTake = sdoReqValid & sdoEnable;
  assign isSeg = (sdoCmd == CMD_DN_SEG) || (sdoCmd == CMD_UP_SEG);
  assign isInit = (sdoCmd == CMD_DN_INIT) || (sdoCmd == CMD_UP_INIT);

  // Protocol checks come before the dictionary's own verdict
  always_comb begin
    reqCause = sdoCause;
    if (sdoCmd > CMD_ABORT) begin
      reqCause = CAUSE_BAD_CMD;
    end else if (isSeg && !segActive) begin
      reqCause = CAUSE_BAD_CMD;
    end else if (isSeg && (sdoToggle != expToggle)) begin
      reqCause = CAUSE_TOGGLE;
    end else if (sdoNeedsPreop && (state != ST_PREOP)) begin
      reqCause = CAUSE_STATE_BLOCKS;
    end
  end

  // A request in the same cycle as the timeout takes precedence
  always_comb begin
    respCause = CAUSE_NONE;
    if (sdoTake) begin
      respCause = reqCause;
    end else if (timeoutHit) begin
      respCause = CAUSE_TIMEOUT;
    end
  end

  assign timeoutHit = segActive && !sdoTake && (idleCount >= SDO_TIMEOUT - 32'h00000001);

  always_ff @(posedge clk_sys) begin
    if (sys_rst || !sdoEnable) begin
      idleCount <= 32'h00000000;
    end else if (!segActive || sdoTake) begin
      idleCount <= 32'h00000000;
    end else begin
      idleCount <= idleCount + 32'h00000001;
    end
  end

  // Segmented transfer bookkeeping; cleared whenever service data stops
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !sdoEnable) begin
      segActive <= 1'b0;
      expToggle <= 1'b0;
    end else if (timeoutHit) begin
      segActive <= 1'b0;
    end else if (sdoTake) begin
      if (sdoCmd == CMD_ABORT) begin
        segActive <= 1'b0;
      end else if (reqCause != CAUSE_NONE) begin
        segActive <= 1'b0;
      end else if (isInit) begin
        segActive <= sdoSegmented;
        expToggle <= 1'b0;
      end else if (isSeg) begin
        expToggle <= ~expToggle;
        segActive <= ~sdoLastSeg;
      end
    end
  end

  fsabl_abort_enc u_abort_enc (
    .cause(respCause),
    .code(respCode)
  );

  // ----------------------------------------------------------------
  // Service-data answer
  // ----------------------------------------------------------------
  // A master abort is never answered
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sdoRespValid <= 1'b0;
      sdoRespAbort <= 1'b0;
      sdoAbortCode <= 32'h00000000;
    end else begin
      sdoRespValid <= (sdoTake && (sdoCmd != CMD_ABORT)) || timeoutHit;
      sdoRespAbort <= (respCause != CAUSE_NONE);
      sdoAbortCode <= respCode;
    end
  end

endmodule : fsabl_top
`default_nettype wire

/* dv/fsabl_master_model.sv */
// Fieldbus master stand-in: drives the distributed-clock SYNC0 pin
`timescale 1ns/10ps
`default_nettype none
module fsabl_master_model (
  input wire logic clk_sys,
  input wire logic syncRun,
  input wire logic [11:0] syncPeriod,
  output logic sync0Pin
);
  logic [11:0] cnt = 12'h000;
  // Counter restarts while stopped, so a new period starts cleanly
  always_ff @(posedge clk_sys) begin
    if (!syncRun || cnt >= syncPeriod - 12'h001) begin
      cnt <= 12'h000;
    end else begin
      cnt <= cnt + 12'h001;
    end
  end
  // Pin rests low when no event runs; no SYNC1 line exists
  assign sync0Pin = syncRun && (cnt < 12'h004);
endmodule : fsabl_master_model
`default_nettype wire

/* dv/fsabl_top_asserts.sv */
// Concurrent checks on the slave state and abort ports
`timescale 1ns/10ps
`default_nettype none
module fsabl_top_asserts
  import fsabl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic stateReqValid,
  input wire logic [3:0] stateReq,
  input wire logic rxPdoValid,
  input wire logic sdoReqValid,
  input wire logic [2:0] sdoCmd,
  input wire logic [3:0] commState,
  input wire logic errorFlag,
  input wire logic stateAck,
  input wire logic stateNak,
  input wire logic sdoEnable,
  input wire logic mailboxEnable,
  input wire logic txPdoEnable,
  input wire logic rxPdoEnable,
  input wire logic rxPdoApply,
  input wire logic rxPdoDropped,
  input wire logic sdoRespValid,
  input wire logic sdoRespAbort,
  input wire logic [31:0] sdoAbortCode
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_onehot; $onehot(commState); endproperty
  a_onehot: assert property (p_onehot)
    else $error("state code not one-hot");
  property p_rst; $fell(sys_rst) |-> commState == CODE_INIT && !errorFlag
    && !sdoEnable && !txPdoEnable && !rxPdoEnable; endproperty
  a_rst: assert property (p_rst)
    else $error("reset state wrong");
  property p_nak; stateNak |-> errorFlag; endproperty
  a_nak: assert property (p_nak)
    else $error("refusal without error flag");
  property p_init; commState == CODE_INIT |->
    !(sdoEnable || mailboxEnable || txPdoEnable || rxPdoEnable); endproperty
  a_init: assert property (p_init)
    else $error("exchange active in init");
  property p_preop; commState == CODE_PREOP |->
    sdoEnable && !txPdoEnable && !rxPdoEnable; endproperty
  a_preop: assert property (p_preop)
    else $error("preop enables wrong");
  property p_safeop; commState == CODE_SAFEOP |->
    sdoEnable && txPdoEnable && !rxPdoEnable; endproperty
  a_safeop: assert property (p_safeop)
    else $error("safeop enables wrong");
  property p_op; commState == CODE_OP |-> sdoEnable && txPdoEnable && rxPdoEnable; endproperty
  a_op: assert property (p_op)
    else $error("op enables wrong");
  property p_ip; stateReqValid && stateReq == CODE_PREOP && commState == CODE_INIT
    |=> stateAck && commState == CODE_PREOP && mailboxEnable; endproperty
  a_ip: assert property (p_ip)
    else $error("init to preop failed");
  property p_resp; sdoReqValid && sdoEnable && sdoCmd != CMD_ABORT |=> sdoRespValid; endproperty
  a_resp: assert property (p_resp)
    else $error("service request unanswered");
  property p_drop; rxPdoValid && commState == CODE_SAFEOP
    |=> rxPdoDropped && !rxPdoApply; endproperty
  a_drop: assert property (p_drop)
    else $error("output data used in safeop");
  property p_code; sdoRespValid |-> sdoRespAbort == (sdoAbortCode != 32'h00000000); endproperty
  a_code: assert property (p_code)
    else $error("abort flag and code disagree");
endmodule : fsabl_top_asserts
`default_nettype wire

/* dv/fsabl_top_bench.sv */
// Self-checking bench for the slave state and abort logic
`timescale 1ns/10ps
`default_nettype none
module fsabl_top_bench;
  import fsabl_pkg::*;
  localparam logic [19:0] SB = 20'h00064;
  localparam logic [31:0] EXP [20] = '{32'h0, 32'h05030000, 32'h05040000, 32'h05040001,
    32'h06010000, 32'h06010001, 32'h06010002, 32'h06010003, 32'h06020000, 32'h06090011,
    32'h06040041, 32'h06040042, 32'h06070010, 32'h06070012, 32'h06070013, 32'h06090030,
    32'h06090031, 32'h06090032, 32'h08000022, 32'h08000000};
  logic clk_sys = 1'b0, sys_rst = 1'b1, stateReqValid = 1'b0, errAck = 1'b0;
  logic rxPdoValid = 1'b0, sdoReqValid = 1'b0, sdoToggle = 1'b0, sdoSegmented = 1'b0;
  logic sdoLastSeg = 1'b0, sdoNeedsPreop = 1'b0, syncRun = 1'b0, sync0Pin;
  logic [3:0] stateReq = 4'h0;
  logic [2:0] sdoCmd = 3'h0;
  logic [11:0] syncPeriod = 12'h064;
  fsabl_cause_type sdoCause = CAUSE_NONE;
  logic [3:0] commState;
  logic errorFlag, stateAck, stateNak, sdoEnable, mailboxEnable, txPdoEnable, rxPdoEnable;
  logic syncOk, txPdoUpdate, rxPdoApply, rxPdoDropped, sdoRespValid, sdoRespAbort;
  logic [31:0] sdoAbortCode;
  int nMismatch = 0, testsRun = 0;
  always #2 clk_sys = ~clk_sys;
  fsabl_master_model mst (.clk_sys(clk_sys), .syncRun(syncRun), .syncPeriod(syncPeriod),
    .sync0Pin(sync0Pin));
  fsabl_top #(.SYNC_BASE(SB), .SYNC_TOL(20'h00005), .SDO_TIMEOUT(32'h00000032)) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .stateReqValid(stateReqValid),
    .stateReq(stateReq), .errAck(errAck), .sync0Pin(sync0Pin), .rxPdoValid(rxPdoValid),
    .sdoReqValid(sdoReqValid), .sdoCmd(sdoCmd), .sdoToggle(sdoToggle),
    .sdoSegmented(sdoSegmented), .sdoLastSeg(sdoLastSeg), .sdoNeedsPreop(sdoNeedsPreop),
    .sdoCause(sdoCause), .commState(commState), .errorFlag(errorFlag), .stateAck(stateAck),
    .stateNak(stateNak), .sdoEnable(sdoEnable), .mailboxEnable(mailboxEnable),
    .txPdoEnable(txPdoEnable), .rxPdoEnable(rxPdoEnable), .syncOk(syncOk),
    .txPdoUpdate(txPdoUpdate), .rxPdoApply(rxPdoApply), .rxPdoDropped(rxPdoDropped),
    .sdoRespValid(sdoRespValid), .sdoRespAbort(sdoRespAbort), .sdoAbortCode(sdoAbortCode));
  // ----------------------------------------
  // Shared drivers and comparison
  // ----------------------------------------
  task chk(input logic [32:0] got, input logic [32:0] exp);
    testsRun++;
    if (got !== exp) begin
      nMismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task req(input logic [3:0] s, input logic ack, input logic [3:0] st);
    @(posedge clk_sys); stateReqValid <= 1'b1; stateReq <= s;
    @(posedge clk_sys); stateReqValid <= 1'b0;
    #1 chk({stateAck, stateNak, commState}, {ack, ~ack, st});
  endtask : req
  task en(input logic [3:0] e);
    chk({sdoEnable, mailboxEnable, txPdoEnable, rxPdoEnable}, e);
  endtask : en
  task clr_err;
    @(posedge clk_sys); errAck <= 1'b1;
    @(posedge clk_sys); errAck <= 1'b0;
    #1 chk(errorFlag, 1'b0);
  endtask : clr_err
  task sdo_go(input logic [2:0] c, input logic tg, sg, np, input fsabl_cause_type cs);
    @(posedge clk_sys); sdoReqValid <= 1'b1; sdoCmd <= c; sdoToggle <= tg;
    sdoSegmented <= sg; sdoNeedsPreop <= np; sdoCause <= cs;
    sdoLastSeg <= sg;
    @(posedge clk_sys); sdoReqValid <= 1'b0;
    #1;
  endtask : sdo_go
  task sdo(input logic [2:0] c, input logic tg, sg, np, input fsabl_cause_type cs,
    input logic [31:0] code);
    sdo_go(c, tg, sg, np, cs);
    chk({sdoRespValid, sdoRespAbort}, {1'b1, code != 32'h0});
    chk(sdoAbortCode, code);
  endtask : sdo
  task pdo(input logic [1:0] e);
    @(posedge clk_sys); rxPdoValid <= 1'b1;
    @(posedge clk_sys); rxPdoValid <= 1'b0;
    #1 chk({rxPdoApply, rxPdoDropped}, e);
  endtask : pdo
  task automatic wait_hi(ref logic s, input int n);
    int k = 0;
    do begin
      @(posedge clk_sys);
      #1 k++;
    end while (s !== 1'b1 && k < n);
  endtask : wait_hi
  task test_done;
    $display("mismatches=%0d checks=%0d", nMismatch, testsRun);
    if (nMismatch == 0 && testsRun > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_init;
    chk({commState, errorFlag, sdoEnable, txPdoEnable, rxPdoEnable}, 8'h10);
    sdo_go(CMD_UP_INIT, 1'b0, 1'b0, 1'b0, CAUSE_NONE);
    chk(sdoRespValid, 1'b0);
    req(CODE_SAFEOP, 1'b0, CODE_INIT);
    chk(errorFlag, 1'b1);
    clr_err();
    req(4'h3, 1'b0, CODE_INIT);
    clr_err();
  endtask : t_init
  task t_preop;
    req(CODE_PREOP, 1'b1, CODE_PREOP);
    en(4'hC);
    for (int i = 0; i < 20; i++) begin
      sdo(CMD_DN_INIT, 0, 0, 0, fsabl_cause_type'(i), EXP[i]);
    end
    sdo(3'h5, 0, 0, 0, CAUSE_NONE, 32'h05040001);
    sdo(CMD_DN_SEG, 0, 0, 0, CAUSE_NONE, 32'h05040001);
    sdo(CMD_DN_INIT, 0, 1, 0, CAUSE_NONE, 32'h0);
    sdo(CMD_DN_SEG, 1, 0, 0, CAUSE_NONE, 32'h05030000);
    sdo(CMD_DN_INIT, 0, 1, 0, CAUSE_NONE, 32'h0);
    sdo(CMD_DN_SEG, 0, 0, 0, CAUSE_NONE, 32'h0);
    wait_hi(sdoRespValid, 80);
    chk({sdoRespValid, sdoAbortCode}, {1'b1, 32'h05040000});
    sdo(CMD_DN_INIT, 0, 1, 0, CAUSE_NONE, 32'h0);
    sdo(CMD_DN_SEG, 0, 1, 0, CAUSE_NONE, 32'h0);
    sdo(CMD_UP_SEG, 0, 0, 0, CAUSE_NONE, 32'h05040001);
    sdo_go(CMD_ABORT, 0, 0, 0, CAUSE_NONE);
    chk(sdoRespValid, 1'b0);
    req(CODE_SAFEOP, 1'b0, CODE_PREOP);
    clr_err();
  endtask : t_preop
  task t_sync;
    syncRun <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      syncPeriod <= 12'(SB << k);
      repeat (3 * int'(SB << k) + 10) @(posedge clk_sys);
      #1 chk(syncOk, 1'b1);
    end
    @(posedge clk_sys); syncPeriod <= 12'(SB);
    repeat (3 * int'(SB) + 10) @(posedge clk_sys);
  endtask : t_sync
  task t_run;
    req(CODE_SAFEOP, 1'b1, CODE_SAFEOP);
    en(4'hE);
    pdo(2'b01);
    wait_hi(txPdoUpdate, int'(SB) + 20);
    chk(txPdoUpdate, 1'b1);
    req(CODE_OP, 1'b1, CODE_OP);
    en(4'hF);
    pdo(2'b10);
    sdo(CMD_DN_INIT, 0, 0, 1, CAUSE_NONE, 32'h08000022);
  endtask : t_run
  task t_exits;
    req(CODE_PREOP, 1'b1, CODE_PREOP);
    en(4'hC);
    req(CODE_SAFEOP, 1'b1, CODE_SAFEOP);
    req(CODE_INIT, 1'b1, CODE_INIT);
    en(4'h0);
    req(CODE_PREOP, 1'b1, CODE_PREOP);
    req(CODE_SAFEOP, 1'b1, CODE_SAFEOP);
    req(CODE_OP, 1'b1, CODE_OP);
    req(CODE_INIT, 1'b1, CODE_INIT);
    en(4'h0);
    req(CODE_PREOP, 1'b1, CODE_PREOP);
    @(posedge clk_sys); syncPeriod <= 12'h096;
    repeat (600) @(posedge clk_sys);
    #1 chk(syncOk, 1'b0);
    req(CODE_SAFEOP, 1'b0, CODE_PREOP);
    req(CODE_INIT, 1'b1, CODE_INIT);
    en(4'h0);
  endtask : t_exits
  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1 t_init();
    t_preop();
    t_sync();
    t_run();
    t_exits();
    test_done();
  end
  // Full run is near 11000 cycles
  initial begin
    #200000;
    nMismatch++;
    test_done();
  end
endmodule : fsabl_top_bench
bind fsabl_top fsabl_top_asserts chk_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .stateReqValid(stateReqValid), .stateReq(stateReq), .rxPdoValid(rxPdoValid),
  .sdoReqValid(sdoReqValid), .sdoCmd(sdoCmd), .commState(commState), .errorFlag(errorFlag),
  .stateAck(stateAck), .stateNak(stateNak), .sdoEnable(sdoEnable),
  .mailboxEnable(mailboxEnable), .txPdoEnable(txPdoEnable), .rxPdoEnable(rxPdoEnable),
  .rxPdoApply(rxPdoApply), .rxPdoDropped(rxPdoDropped), .sdoRespValid(sdoRespValid),
  .sdoRespAbort(sdoRespAbort), .sdoAbortCode(sdoAbortCode));
`default_nettype wire
